//--- iotic_core.sv
// I/O transfer instruction and interrupt sequencer with APB register access
`include "iotic_defs.svh"
// ********************************************************************
// I/O transfer and interrupt core
// ********************************************************************
// Operation
// - One transfer instruction moves exactly one word in, out of acc or memory.
// - Operand address drives the adapter register selector during a transfer.
// - Up to 26 discretes packed into one transferred word.
// - Exclusive-or against prior copy flags every changed discrete input.
// - Logical-and on output word forces chosen discretes before writeback.
// - Adapter interrupt request suspends program and enters the subprogram.
// - Entry address comes from a branch constant at a fixed location.
// - Timed interrupt period is software set and changeable at run time.
// - Taking interrupt saves counter, sector and syllable to a fixed location.
// - Branch from saved location restores counter, sector, syllable and resumes.
// - Data word is 26 bits plus 2 parity, two memory cycles.
module iotic_core
  import iotic_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Adapter link
  output iotic_io_s io_out,
  input wire logic [25:0] io_in_data,
  input wire logic io_int_req,
  // Interrupt
  output logic irq
);

  // ********************************************************************
  // Storage
  // ********************************************************************
  // Memory of 13-bit syllables with parity, two per data word
  logic [13:0] mem [0:`IOTIC_MEM_DEPTH-1];

  // State
  iotic_state_e state, next_state;
  iotic_op_e op, next_op;
  logic [8:0] operand, next_operand;
  logic [25:0] acc, next_acc;
  logic [25:0] mem_word, next_mem_word;
  logic [25:0] prev_in, next_prev_in;
  logic [25:0] diff, next_diff;
  logic [31:0] period, next_period;
  logic [31:0] tcount, next_tcount;
  logic [2:0] stat, next_stat;
  logic [2:0] mask, next_mask;
  iotic_ctx_s ctx, next_ctx;
  logic busy, next_busy;
  logic int_pend, next_int_pend;
  iotic_io_s next_io;
  logic [31:0] next_prdata;
  logic mem_we;
  logic [8:0] mem_wa;
  logic [13:0] mem_wd;
  logic [2:0] req_sync;
  logic req_level, next_req_level;
  logic [2:0] stat_set, stat_clr;
  logic rd_setup;

  // ********************************************************************
  // Helpers
  // ********************************************************************
  // Odd parity over one syllable
  function automatic logic [13:0] with_par(input logic [12:0] d);
    with_par = {~^d, d};
  endfunction

  // Decode one APB address match
  function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
    hit = (a == r);
  endfunction

  // ********************************************************************
  // Bus decode
  // ********************************************************************
  // Writes land at the access edge; read data is registered in the setup
  // cycle so that it already stands while pready is sampled
  logic wr_acc, rd_acc;
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign irq = |(stat & mask);

  // ********************************************************************
  // Adapter request synchroniser
  // ********************************************************************
  // Three-stage pin synchroniser for the adapter request
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      req_sync <= 3'h0;
    end else begin
      req_sync <= {req_sync[1:0], io_int_req};
    end
  end

  // ********************************************************************
  // Sequencer
  // ********************************************************************
  // Next values of sequencer and registers
  always_comb begin
    next_state = state;
    next_op = op;
    next_operand = operand;
    next_acc = acc;
    next_mem_word = mem_word;
    next_prev_in = prev_in;
    next_diff = diff;
    next_period = period;
    next_tcount = tcount;
    next_stat = stat;
    next_mask = mask;
    next_ctx = ctx;
    next_busy = busy;
    next_int_pend = int_pend;
    next_req_level = req_level;
    next_io = '0;
    next_prdata = prdata;
    pslverr = 1'b0;
    stat_set = 3'h0;
    stat_clr = 3'h0;
    mem_we = 1'b0;
    mem_wa = 9'h000;
    mem_wd = 14'h0000;
    // Request counts once second and third stages agree
    if (req_sync[2] == req_sync[1]) begin
      next_req_level = req_sync[2];
    end
    if (next_req_level && !req_level) begin
      next_int_pend = 1'b1;
    end
    // Programmable timed interrupt
    if (period != 32'h0) begin
      if (tcount >= period - 32'h1) begin
        next_tcount = 32'h0;
        next_int_pend = 1'b1;
        stat_set[`IOTIC_ST_TIMER] = 1'b1;
      end else begin
        next_tcount = tcount + 32'h1;
      end
    end
    case (state)
      ST_IDLE: begin
        if (busy) begin
          next_state = (op == OP_NONE) ? ST_IDLE : ST_RD_LO;
          next_busy = (op != OP_NONE);
        end else if (int_pend) begin
          // Boundary only: a started instruction runs to its end first
          next_int_pend = 1'b0;
          next_busy = 1'b1;
          next_state = ST_SAVE_LO;
        end
      end
      ST_RD_LO: begin
        next_mem_word[12:0] = mem[operand][12:0];
        next_state = ST_RD_HI;
      end
      ST_RD_HI: begin
        next_mem_word[25:13] = mem[operand + 9'h1][12:0];
        // Selector leads the strobe so the adapter word is settled at the transfer edge
        if (op == OP_IO_IN || op == OP_IO_OUT_ACC || op == OP_IO_OUT_MEM) begin
          next_io.sel = operand;
        end
        next_state = ST_XFER;
      end
      ST_XFER: begin
        next_state = ST_IDLE;
        next_busy = 1'b0;
        next_op = OP_NONE;
        stat_set[`IOTIC_ST_DONE] = 1'b1;
        case (op)
          OP_IO_IN: begin
            next_io.rd = 1'b1;
            next_io.sel = operand;
            next_acc = io_in_data;
          end
          OP_IO_OUT_ACC: begin
            next_io.wr = 1'b1;
            next_io.sel = operand;
            next_io.data = acc;
          end
          OP_IO_OUT_MEM: begin
            next_io.wr = 1'b1;
            next_io.sel = operand;
            next_io.data = mem_word;
          end
          OP_XOR: begin
            next_diff = acc ^ mem_word;
            next_acc = acc ^ mem_word;
            next_prev_in = acc;
          end
          OP_AND: begin
            next_acc = acc & mem_word;
          end
          OP_HOP: begin
            // Reload context from the word at the operand
            next_ctx = mem_word[13:0];
          end
          default: begin
            next_busy = 1'b0;
          end
        endcase
      end
      ST_SAVE_LO: begin
        // Save the low context syllable and fetch the entry constant in the same cycle
        mem_we = 1'b1;
        mem_wa = `IOTIC_SAVE_LOC;
        mem_wd = with_par(ctx[12:0]);
        next_mem_word = {13'h0, mem[`IOTIC_ENTRY_LOC][12:0]};
        next_state = ST_SAVE_HI;
      end
      ST_SAVE_HI: begin
        // High context bit goes to the next syllable, so the branch reloads it whole
        mem_we = 1'b1;
        mem_wa = `IOTIC_SAVE_LOC + 9'h001;
        mem_wd = with_par({12'h000, ctx[13]});
        next_ctx = {1'b0, mem_word[12:0]};
        stat_set[`IOTIC_ST_INT] = 1'b1;
        next_busy = 1'b0;
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    // APB writes
    if (wr_acc) begin
      case (paddr)
        `IOTIC_CTRL_ADDR: next_busy = pwdata[0];
        `IOTIC_OPCODE_ADDR: next_op = iotic_op_e'(pwdata[3:0]);
        `IOTIC_OPERAND_ADDR: next_operand = pwdata[8:0];
        `IOTIC_ACC_ADDR: next_acc = pwdata[25:0];
        `IOTIC_IRQ_STAT_ADDR: stat_clr = pwdata[2:0];
        `IOTIC_IRQ_MASK_ADDR: next_mask = pwdata[2:0];
        `IOTIC_PERIOD_ADDR: next_period = pwdata;
        `IOTIC_IC_ADDR: next_ctx = pwdata[13:0];
        default: begin
          if (paddr >= `IOTIC_MEM_BASE && paddr[1:0] == 2'b00) begin
            // The context save owns the write port; a bus write then is dropped
            if (state != ST_SAVE_LO && state != ST_SAVE_HI) begin
              mem_we = 1'b1;
              mem_wa = 9'(paddr[10:2] - 9'h040);
              mem_wd = with_par(pwdata[12:0]);
            end
          end else begin
            pslverr = 1'b1;
          end
        end
      endcase
    end
    // Events set status bits; a set wins over a clear in the same cycle
    next_stat = (stat & ~stat_clr) | stat_set;
    // APB reads: decoded in the setup cycle, error raised in the access cycle
    if (rd_setup || rd_acc) begin
      next_prdata = `IOTIC_ERR_RESP;
      if (hit(paddr, `IOTIC_CTRL_ADDR)) next_prdata = {31'h0, busy};
      else if (hit(paddr, `IOTIC_OPCODE_ADDR)) next_prdata = {28'h0, op};
      else if (hit(paddr, `IOTIC_OPERAND_ADDR)) next_prdata = {23'h0, operand};
      else if (hit(paddr, `IOTIC_ACC_ADDR)) next_prdata = {6'h0, acc};
      else if (hit(paddr, `IOTIC_MEMDATA_ADDR)) next_prdata = {6'h0, mem_word};
      else if (hit(paddr, `IOTIC_STATUS_ADDR)) next_prdata = {27'h0, state, int_pend, busy};
      else if (hit(paddr, `IOTIC_IRQ_STAT_ADDR)) next_prdata = {29'h0, stat};
      else if (hit(paddr, `IOTIC_IRQ_MASK_ADDR)) next_prdata = {29'h0, mask};
      else if (hit(paddr, `IOTIC_PERIOD_ADDR)) next_prdata = period;
      else if (hit(paddr, `IOTIC_IC_ADDR)) next_prdata = {18'h0, ctx};
      else if (hit(paddr, `IOTIC_SAVED_ADDR)) next_prdata = {18'h0, mem[`IOTIC_SAVE_LOC]};
      else if (hit(paddr, `IOTIC_PREV_ADDR)) next_prdata = {6'h0, prev_in};
      else if (hit(paddr, `IOTIC_DIFF_ADDR)) next_prdata = {6'h0, diff};
      else if (paddr >= `IOTIC_MEM_BASE && paddr[1:0] == 2'b00)
        next_prdata = {18'h0, mem[9'(paddr[10:2] - 9'h040)]};
      else pslverr = rd_acc;
    end
    // Only the setup cycle loads the read register
    if (!rd_setup) begin
      next_prdata = prdata;
    end
  end

  // ********************************************************************
  // State registers
  // ********************************************************************
  // Register all state
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state <= ST_IDLE;
      op <= OP_NONE;
      operand <= 9'h000;
      acc <= 26'h0;
      mem_word <= 26'h0;
      prev_in <= 26'h0;
      diff <= 26'h0;
      period <= `IOTIC_PERIOD_RST;
      tcount <= 32'h0;
      stat <= 3'h0;
      mask <= 3'h0;
      ctx <= '0;
      busy <= 1'b0;
      int_pend <= 1'b0;
      req_level <= 1'b0;
      io_out <= '0;
      prdata <= 32'h0;
    end else begin
      state <= next_state;
      op <= next_op;
      operand <= next_operand;
      acc <= next_acc;
      mem_word <= next_mem_word;
      prev_in <= next_prev_in;
      diff <= next_diff;
      period <= next_period;
      tcount <= next_tcount;
      stat <= next_stat;
      mask <= next_mask;
      ctx <= next_ctx;
      busy <= next_busy;
      int_pend <= next_int_pend;
      req_level <= next_req_level;
      io_out <= next_io;
      prdata <= next_prdata;
    end
  end

  // ********************************************************************
  // Memory port
  // ********************************************************************
  // Memory write port
  always_ff @(posedge ref_clk) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

endmodule // iotic_core

//--- iotic_defs.svh
// Constants for the I/O transfer and interrupt block
`ifndef IOTIC_DEFS_SVH
`define IOTIC_DEFS_SVH
// ********************************************************************
// Register map (byte addresses)
// ********************************************************************
`define IOTIC_CTRL_ADDR 12'h000
`define IOTIC_OPCODE_ADDR 12'h004
`define IOTIC_OPERAND_ADDR 12'h008
`define IOTIC_ACC_ADDR 12'h00c
`define IOTIC_MEMDATA_ADDR 12'h010
`define IOTIC_STATUS_ADDR 12'h014
`define IOTIC_IRQ_STAT_ADDR 12'h018
`define IOTIC_IRQ_MASK_ADDR 12'h01c
`define IOTIC_PERIOD_ADDR 12'h020
`define IOTIC_IC_ADDR 12'h024
`define IOTIC_SAVED_ADDR 12'h028
`define IOTIC_PREV_ADDR 12'h02c
`define IOTIC_DIFF_ADDR 12'h030
`define IOTIC_MEM_BASE 12'h100
// ********************************************************************
// Fields and sizes
// ********************************************************************
`define IOTIC_WORD_W 26
`define IOTIC_HALF_W 13
`define IOTIC_ADDR_W 9
`define IOTIC_MEM_DEPTH 512
`define IOTIC_ENTRY_LOC 9'h000
`define IOTIC_SAVE_LOC 9'h001
`define IOTIC_PERIOD_RST 32'h0000_4e20
`define IOTIC_ST_DONE 0
`define IOTIC_ST_INT 1
`define IOTIC_ST_TIMER 2
`define IOTIC_ERR_RESP 32'h0000_0000
`endif

//--- iotic_pkg.sv
// Types for the I/O transfer and interrupt block
package iotic_pkg;
  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_IO_IN = 4'h1,
    OP_IO_OUT_ACC = 4'h2,
    OP_IO_OUT_MEM = 4'h3,
    OP_XOR = 4'h4,
    OP_AND = 4'h5,
    OP_HOP = 4'h6
  } iotic_op_e;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RD_LO = 3'b001,
    ST_RD_HI = 3'b010,
    ST_XFER = 3'b011,
    ST_SAVE_LO = 3'b100,
    ST_SAVE_HI = 3'b101
  } iotic_state_e;
  typedef struct packed {
    logic [8:0] ic;
    logic [3:0] sector;
    logic syllable;
  } iotic_ctx_s;
  typedef struct packed {
    logic rd;
    logic wr;
    logic [8:0] sel;
    logic [25:0] data;
  } iotic_io_s;
endpackage : iotic_pkg

//--- iotic_core_chk.sv
// Port-level checker for the I/O transfer and interrupt core
`include "iotic_defs.svh"
// ****************************************
// Checker
// ****************************************
module iotic_core_chk
  import iotic_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Adapter link and interrupt
  input wire iotic_io_s io_out,
  input wire logic [25:0] io_in_data,
  input wire logic io_int_req,
  input wire logic irq
);
  logic acc_w;
  logic [3:0] op_q, next_op;
  logic [8:0] opnd_q, next_opnd;
  logic [2:0] mask_q, next_mask;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  assign acc_w = psel && penable && pwrite;
  // Shadow of opcode, operand and mask writes
  always_comb begin
    next_op = op_q;
    next_opnd = opnd_q;
    next_mask = mask_q;
    if (acc_w && paddr == `IOTIC_OPCODE_ADDR) next_op = pwdata[3:0];
    if (acc_w && paddr == `IOTIC_OPERAND_ADDR) next_opnd = pwdata[8:0];
    if (acc_w && paddr == `IOTIC_IRQ_MASK_ADDR) next_mask = pwdata[2:0];
  end
  // Shadow registers
  always_ff @(posedge ref_clk) begin
    op_q <= reset ? 4'h0 : next_op;
    opnd_q <= reset ? 9'h000 : next_opnd;
    mask_q <= reset ? 3'h0 : next_mask;
  end
  sequence start_s;
    acc_w && paddr == `IOTIC_CTRL_ADDR && pwdata[0];
  endsequence
  sequence pulse_s;
    io_out.rd || io_out.wr;
  endsequence
  xfer_pulse_a: assert property (start_s ##0 op_q inside {[1:3]} |-> ##[1:8] pulse_s)
    else $error("no transfer strobe after start");
  rd_pulse_a: assert property (io_out.rd |=> !io_out.rd)
    else $error("read strobe longer than one cycle");
  wr_pulse_a: assert property (io_out.wr |=> !io_out.wr)
    else $error("write strobe longer than one cycle");
  rd_dir_a: assert property (io_out.rd |-> op_q == 4'h1 && !io_out.wr)
    else $error("read strobe for wrong opcode");
  wr_dir_a: assert property (io_out.wr |-> op_q inside {4'h2, 4'h3})
    else $error("write strobe for wrong opcode");
  sel_opnd_a: assert property (pulse_s |-> io_out.sel == opnd_q)
    else $error("selector differs from operand");
  ready_high_a: assert property (pready)
    else $error("pready low");
  err_unmapped_a: assert property (psel && penable && paddr == 12'h034 |-> pslverr)
    else $error("no error on unmapped address");
  err_mapped_a: assert property (psel && penable && paddr == `IOTIC_PERIOD_ADDR |-> !pslverr)
    else $error("error on mapped address");
  irq_mask_a: assert property (mask_q == 3'h0 |-> !irq)
    else $error("interrupt with all sources masked");
endmodule // iotic_core_chk

bind iotic_core iotic_core_chk iotic_core_chk_i (.ref_clk(ref_clk), .reset(reset),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .io_out(io_out),
  .io_in_data(io_in_data), .io_int_req(io_int_req), .irq(irq));

//--- iotic_adapter.sv
// Behavioural model of the external I/O adapter unit
module iotic_adapter
  import iotic_pkg::*;
(
  // Clock
  input wire logic ref_clk,
  // Link from the core
  input wire iotic_io_s io_out,
  input wire logic raise,
  output logic [25:0] io_in_data,
  output logic io_int_req
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [25:0] regs [0:511];
  logic [2:0] hold = 3'h0;
  // Preset word registers with a per-select pattern
  initial begin
    for (int i = 0; i < 512; i++) begin
      regs[i] = 26'h2a5a5a5 ^ 26'(i);
    end
  end
  // Selected register drives the packed input word
  assign io_in_data = regs[io_out.sel];
  assign io_int_req = hold != 3'h0;
  // Capture write strobes; stretch the interrupt request
  always @(posedge ref_clk) begin
    if (io_out.wr) begin
      regs[io_out.sel] <= io_out.data;
    end
    hold <= raise ? 3'h6 : (hold != 3'h0 ? hold - 3'h1 : 3'h0);
  end
endmodule // iotic_adapter

//--- test_io_transfer_interrupt.sv
// Self-checking bench for the I/O transfer and interrupt core
`include "iotic_defs.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin failures++; \
  $display("mismatch at %0t got %h want %h", $time, g, e); end end
// ****************************************
// Bench
// ****************************************
module test_io_transfer_interrupt import iotic_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0, reset = 1'b1, raise = 1'b0, err;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, irq;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [25:0] io_in_data;
  logic io_int_req;
  iotic_io_s io_out;
  int failures = 0, tests_run = 0;
  always #25 ref_clk = ~ref_clk;
  iotic_core iotic_core_i (.ref_clk(ref_clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .io_out(io_out), .io_in_data(io_in_data),
    .io_int_req(io_int_req), .irq(irq));
  iotic_adapter iotic_adapter_i (.ref_clk(ref_clk), .io_out(io_out), .raise(raise),
    .io_in_data(io_in_data), .io_int_req(io_int_req));
  // One APB transfer; read data and error are taken at the access edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    err = pslverr;
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  // Read until a bit reaches a value
  task automatic poll(input logic [11:0] a, input int b, input logic v);
    rd[b] = ~v;
    for (int n = 0; n < 40 && rd[b] !== v; n++) apb(1'b0, a, 32'h0);
  endtask
  // Start one instruction and wait for it to finish
  task automatic run_op(input logic [3:0] op, input logic [8:0] sel);
    apb(1'b1, `IOTIC_OPERAND_ADDR, {23'h0, sel});
    apb(1'b1, `IOTIC_OPCODE_ADDR, {28'h0, op});
    apb(1'b1, `IOTIC_CTRL_ADDR, 32'h1);
    poll(`IOTIC_STATUS_ADDR, 0, 1'b0);
    `CHK(rd[0], 1'b0)
  endtask
  task automatic note(input string s);
    $display("test %s done", s);
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    apb(1'b0, `IOTIC_PERIOD_ADDR, 32'h0);
    `CHK(rd, `IOTIC_PERIOD_RST)
    `CHK(irq, 1'b0)
    note("reset");
    run_op(4'h1, 9'h005);
    apb(1'b0, `IOTIC_ACC_ADDR, 32'h0);
    `CHK(rd[25:0], 26'h2a5a5a5 ^ 26'h5)
    apb(1'b1, `IOTIC_ACC_ADDR, 32'h0155_aa55);
    run_op(4'h2, 9'h009);
    `CHK(iotic_adapter_i.regs[9], 26'h155_aa55)
    apb(1'b1, 12'h150, 32'h0000_1abc);
    apb(1'b1, 12'h154, 32'h0000_0123);
    run_op(4'h3, 9'h014);
    `CHK(iotic_adapter_i.regs[20], {13'h0123, 13'h1abc})
    apb(1'b1, 12'h1c0, 32'h0000_0f0f);
    apb(1'b1, 12'h1c4, 32'h0000_00ff);
    apb(1'b1, `IOTIC_ACC_ADDR, 32'h0155_aa55);
    run_op(4'h4, 9'h030);
    apb(1'b0, `IOTIC_MEMDATA_ADDR, 32'h0);
    `CHK(rd[25:0], {13'h00ff, 13'h0f0f})
    apb(1'b0, `IOTIC_DIFF_ADDR, 32'h0);
    `CHK(rd[25:0], 26'h155_aa55 ^ {13'h00ff, 13'h0f0f})
    apb(1'b0, `IOTIC_PREV_ADDR, 32'h0);
    `CHK(rd[25:0], 26'h155_aa55)
    apb(1'b1, `IOTIC_ACC_ADDR, 32'h03ff_ffff);
    run_op(4'h5, 9'h030);
    apb(1'b0, `IOTIC_ACC_ADDR, 32'h0);
    `CHK(rd[25:0], {13'h00ff, 13'h0f0f})
    note("discretes");
    note("transfer");
    apb(1'b0, 12'h034, 32'h0);
    `CHK(err, 1'b1)
    `CHK(rd, `IOTIC_ERR_RESP)
    note("unmapped");
    apb(1'b1, `IOTIC_IC_ADDR, 32'h0000_2a5b);
    apb(1'b1, `IOTIC_MEM_BASE, 32'h0000_0123);
    raise <= 1'b1;
    @(posedge ref_clk);
    raise <= 1'b0;
    poll(`IOTIC_IRQ_STAT_ADDR, `IOTIC_ST_INT, 1'b1);
    `CHK(rd[`IOTIC_ST_INT], 1'b1)
    apb(1'b0, `IOTIC_IC_ADDR, 32'h0);
    `CHK(rd[13:0], 14'h0123)
    apb(1'b0, `IOTIC_SAVED_ADDR, 32'h0);
    `CHK(rd[13:0], 14'h0a5b)
    apb(1'b0, 12'h108, 32'h0);
    `CHK(rd[13:0], 14'h0001)
    run_op(4'h6, `IOTIC_SAVE_LOC);
    apb(1'b0, `IOTIC_IC_ADDR, 32'h0);
    `CHK(rd[13:0], 14'h2a5b)
    `CHK(irq, 1'b0)
    apb(1'b1, `IOTIC_IRQ_MASK_ADDR, 32'h2);
    `CHK(irq, 1'b1)
    apb(1'b1, `IOTIC_IRQ_STAT_ADDR, 32'h2);
    `CHK(irq, 1'b0)
    note("interrupt");
    apb(1'b1, `IOTIC_PERIOD_ADDR, 32'd40);
    apb(1'b1, `IOTIC_IRQ_MASK_ADDR, 32'h4);
    poll(`IOTIC_IRQ_STAT_ADDR, `IOTIC_ST_TIMER, 1'b1);
    `CHK(irq, 1'b1)
    apb(1'b1, `IOTIC_PERIOD_ADDR, 32'h0);
    apb(1'b1, `IOTIC_IRQ_STAT_ADDR, 32'h4);
    `CHK(irq, 1'b0)
    note("timer");
    end_sim;
  end
  // Watchdog against a hung handshake
  initial begin
    repeat (4000) @(posedge ref_clk);
    failures++;
    $display("mismatch at %0t watchdog expired", $time);
    end_sim;
  end
endmodule // test_io_transfer_interrupt
